// file: rtl/prog_clock_pkg.sv
// shared constants for the programmable clock and clock status block
package prog_clock_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_PROG_CLOCK_CONFIG0 = 32'h400E_0440;
  localparam logic [31:0] ADDR_CLOCK_IRQ_ENABLE   = 32'h400E_0460;
  localparam logic [31:0] ADDR_CLOCK_IRQ_DISABLE  = 32'h400E_0464;
  localparam logic [31:0] ADDR_CLOCK_STATUS       = 32'h400E_0468;
  localparam logic [31:0] ADDR_CLOCK_IRQ_MASK     = 32'h400E_046C;
  localparam logic [31:0] ADDR_CONFIG_STRIDE      = 32'h0000_0004;

  localparam int unsigned NUM_PROG_CLOCKS = 3;

  // configuration fields
  localparam int unsigned SRC_SEL_LSB    = 0;
  localparam int unsigned PRESCALE_LSB   = 4;
  localparam int unsigned CNT_WIDTH      = 7;
  localparam logic [2:0]  SRC_SEL_RESET  = 3'h0;
  localparam logic [2:0]  PRESCALE_RESET = 3'h0;
  localparam logic [2:0]  PRESCALE_MAX   = 3'h6;

  typedef enum logic [2:0]
  {
    SRC_SLOW   = 3'h0,
    SRC_MAIN   = 3'h1,
    SRC_PLL_A  = 3'h2,
    SRC_MASTER = 3'h4
  } clock_source_t;

  // status bit positions
  localparam int unsigned BIT_CRYSTAL_OSC_STABLE   = 0;
  localparam int unsigned BIT_PLL_A_LOCKED         = 1;
  localparam int unsigned BIT_MASTER_CLOCK_READY   = 3;
  localparam int unsigned BIT_SLOW_OSC_SELECT      = 7;
  localparam int unsigned BIT_PROG_CLOCK_READY0    = 8;
  localparam int unsigned BIT_MAIN_OSC_SWITCH_DONE = 16;
  localparam int unsigned BIT_FAST_RC_STABLE       = 17;
  localparam int unsigned BIT_CLOCK_FAIL_EVENT     = 18;
  localparam int unsigned BIT_CLOCK_FAIL_STATUS    = 19;
  localparam int unsigned BIT_FAULT_OUTPUT_STATUS  = 20;
  localparam int unsigned BIT_SLOW_XTAL_FREQ_ERROR = 21;

  // bits that may hold an interrupt enable
  localparam logic [31:0] IRQ_VALID_BITS = 32'h0027_070B;
  localparam logic [31:0] IMR_RESET      = 32'h0000_0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;
endpackage

// file: rtl/prog_clock_status.sv
// programmable clock outputs and clock status/interrupt registers on AHB-Lite
// Functional notes
// - writes to config ignored while write-protect set
// - source 0 slow, 1 main, 2 PLL, 4 master
// - prescaler 0..6 divides by 1 to 64; with source 4 (master) it divides hclk by 2 to 128
// - enable register sets mask for stable, lock, ready
// - enable register also covers bits 16,17,18,21
// - disable register clears mask, same bit layout
// - status bit 0 shows crystal oscillator stable
// - status bit 1 shows PLL A locked
// - status bit 3 shows master clock ready
// - status bit 7 shows slow oscillator selection
// - status bits 8-10 show programmable clocks ready
// - status bit 16 shows main oscillator switch done
// - status bit 17 shows fast RC stable
// - clock fail event sticky until status read
// - read-only mask register shows enabled interrupts
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module prog_clock_status
  import prog_clock_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // write protection from the protect unit
  input  wire logic        write_protect_enable,
  // clock sources from the oscillators and PLL
  input  wire logic        slow_clock_source,
  input  wire logic        main_clock_source,
  input  wire logic        pll_a_clock_source,
  // status from the clock units
  input  wire logic        crystal_osc_stable,
  input  wire logic        pll_a_locked,
  input  wire logic        master_clock_ready,
  input  wire logic        slow_osc_select_status,
  input  wire logic        main_osc_switch_done,
  input  wire logic        fast_rc_stable,
  input  wire logic        clock_fail_status,
  input  wire logic        fault_output_status,
  input  wire logic        slow_crystal_freq_error,
  // outputs
  output logic [2:0]       prog_clock_out,
  output logic             irq
);

  localparam int unsigned NUM_ASYNC = 12;

  // address decode shared by read and write paths
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] base);
    hit = (addr == base);
  endfunction

  function automatic int unsigned cfg_index(input logic [31:0] addr);
    cfg_index = NUM_PROG_CLOCKS;
    for (int unsigned k = 0; k < NUM_PROG_CLOCKS; k++)
    begin
      if (addr == ADDR_PROG_CLOCK_CONFIG0 + k * ADDR_CONFIG_STRIDE)
      begin
        cfg_index = k;
      end
    end
  endfunction

  // two-flop synchronisers for everything arriving from outside this clock
  logic [NUM_ASYNC-1:0] async_in;
  logic [NUM_ASYNC-1:0] sync_stage1;
  logic [NUM_ASYNC-1:0] sync_in;
  logic [2:0]           src_last;

  assign async_in = {slow_crystal_freq_error, fault_output_status, clock_fail_status,
                     fast_rc_stable, main_osc_switch_done, slow_osc_select_status,
                     master_clock_ready, pll_a_locked, crystal_osc_stable,
                     pll_a_clock_source, main_clock_source, slow_clock_source};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_stage1 <= '0;
      sync_in     <= '0;
      src_last    <= 3'h0;
    end
    else
    begin
      sync_stage1 <= async_in;
      sync_in     <= sync_stage1;
      src_last    <= sync_in[2:0];
    end
  end

  logic       s_slow_xtal_err;
  logic       s_fault_out;
  logic       s_fail_status;
  logic       s_fast_rc;
  logic       s_switch_done;
  logic       s_slow_sel;
  logic       s_master_ready;
  logic       s_pll_lock;
  logic       s_xtal_stable;
  logic [2:0] src_toggle;

  assign {s_slow_xtal_err, s_fault_out, s_fail_status, s_fast_rc, s_switch_done,
          s_slow_sel, s_master_ready, s_pll_lock, s_xtal_stable} = sync_in[11:3];
  assign src_toggle = sync_in[2:0] ^ src_last;

  // ahb-lite address phase capture; the slave never inserts wait states
  logic        dp_valid;
  logic        dp_write;
  logic [31:0] dp_addr;
  logic        addr_accept;

  assign addr_accept = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign hreadyout   = 1'b1;
  assign hresp       = HRESP_OKAY;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 32'h0000_0000;
    end
    else
    begin
      dp_valid <= addr_accept;
      dp_write <= addr_accept && hwrite;
      dp_addr  <= haddr;
    end
  end

  logic wr_irq_en;
  logic wr_irq_dis;
  logic rd_status;
  logic [NUM_PROG_CLOCKS-1:0] wr_cfg;

  assign wr_irq_en  = dp_write && hit(dp_addr, ADDR_CLOCK_IRQ_ENABLE);
  assign wr_irq_dis = dp_write && hit(dp_addr, ADDR_CLOCK_IRQ_DISABLE);
  assign rd_status = addr_accept && !hwrite && hit(haddr, ADDR_CLOCK_STATUS);

  // per-channel source select, prescaler and ready
  logic [2:0]           src_sel   [NUM_PROG_CLOCKS];
  logic [2:0]           prescale  [NUM_PROG_CLOCKS];
  logic [CNT_WIDTH-1:0] div_cnt   [NUM_PROG_CLOCKS];
  logic [NUM_PROG_CLOCKS-1:0] prog_clock_ready;

  genvar g;
  generate
    for (g = 0; g < NUM_PROG_CLOCKS; g++)
    begin : gen_pck
      logic                 tick;
      logic [CNT_WIDTH-1:0] next_cnt;
      logic                 valid_sel;

      assign wr_cfg[g] = dp_write && !write_protect_enable
                         && (cfg_index(dp_addr) == g);

      always_comb
      begin
        case (src_sel[g])
          SRC_SLOW:   tick = src_toggle[0];
          SRC_MAIN:   tick = src_toggle[1];
          SRC_PLL_A:  tick = src_toggle[2];
          SRC_MASTER: tick = 1'b1;
          default:    tick = 1'b0;
        endcase
      end

      assign valid_sel = (prescale[g] <= PRESCALE_MAX);
      assign next_cnt  = div_cnt[g] + CNT_WIDTH'(tick);

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          src_sel[g]  <= SRC_SEL_RESET;
          prescale[g] <= PRESCALE_RESET;
        end
        else if (wr_cfg[g])
        begin
          src_sel[g]  <= hwdata[SRC_SEL_LSB +: 3];
          prescale[g] <= hwdata[PRESCALE_LSB +: 3];
        end
      end

      // counter of source edges; bit n is the source divided by 2**n, or hclk divided by 2**(n+1) for master
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          div_cnt[g] <= '0;
        end
        else if (wr_cfg[g])
        begin
          div_cnt[g] <= '0;
        end
        else
        begin
          div_cnt[g] <= next_cnt;
        end
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          prog_clock_out[g] <= 1'b0;
        end
        else if (wr_cfg[g] || !valid_sel)
        begin
          prog_clock_out[g] <= 1'b0;
        end
        else
        begin
          prog_clock_out[g] <= next_cnt[prescale[g]];
        end
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          prog_clock_ready[g] <= 1'b0;
        end
        else if (wr_cfg[g])
        begin
          prog_clock_ready[g] <= 1'b0;
        end
        else if (valid_sel && !div_cnt[g][prescale[g]] && next_cnt[prescale[g]])
        begin
          prog_clock_ready[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // clock failure event: sticky, cleared by a status read, a new event wins
  logic fail_last;
  logic clock_fail_event;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fail_last        <= 1'b0;
      clock_fail_event <= 1'b0;
    end
    else
    begin
      fail_last <= s_fail_status;
      if (s_fail_status && !fail_last)
      begin
        clock_fail_event <= 1'b1;
      end
      else if (rd_status)
      begin
        clock_fail_event <= 1'b0;
      end
    end
  end

  logic [31:0] status_word;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[BIT_CRYSTAL_OSC_STABLE]   = s_xtal_stable;
    status_word[BIT_PLL_A_LOCKED]         = s_pll_lock;
    status_word[BIT_MASTER_CLOCK_READY]   = s_master_ready;
    status_word[BIT_SLOW_OSC_SELECT]      = s_slow_sel;
    status_word[BIT_PROG_CLOCK_READY0 +: NUM_PROG_CLOCKS] = prog_clock_ready;
    status_word[BIT_MAIN_OSC_SWITCH_DONE] = s_switch_done;
    status_word[BIT_FAST_RC_STABLE]       = s_fast_rc;
    status_word[BIT_CLOCK_FAIL_EVENT]     = clock_fail_event;
    status_word[BIT_CLOCK_FAIL_STATUS]    = s_fail_status;
    status_word[BIT_FAULT_OUTPUT_STATUS]  = s_fault_out;
    status_word[BIT_SLOW_XTAL_FREQ_ERROR] = s_slow_xtal_err;
  end

  // interrupt mask: set by enable writes, cleared by disable writes
  logic [31:0] imr;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      imr <= IMR_RESET;
    end
    else
    begin
      imr <= (imr | ({32{wr_irq_en}} & hwdata & IRQ_VALID_BITS))
             & ~({32{wr_irq_dis}} & hwdata & IRQ_VALID_BITS);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_word & imr);
    end
  end

  // read data is registered in the address phase; unmapped reads give zero
  logic [31:0] next_rdata;
  int unsigned rd_idx;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    rd_idx     = cfg_index(haddr);
    if (hit(haddr, ADDR_CLOCK_STATUS))
    begin
      next_rdata = status_word;
    end
    else if (hit(haddr, ADDR_CLOCK_IRQ_MASK))
    begin
      next_rdata = imr;
    end
    else if (rd_idx < NUM_PROG_CLOCKS)
    begin
      next_rdata[SRC_SEL_LSB +: 3]  = src_sel[rd_idx];
      next_rdata[PRESCALE_LSB +: 3] = prescale[rd_idx];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (addr_accept && !hwrite)
    begin
      hrdata <= next_rdata;
    end
  end

  // checks
  a_wp_blocks_cfg: assert property (@(posedge hclk) disable iff (!hresetn)
    dp_write && write_protect_enable && hit(dp_addr, ADDR_PROG_CLOCK_CONFIG0)
    |=> $stable(src_sel[0]) && $stable(prescale[0]))
    else $error("config changed while write protected");
  a_master_src_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    src_sel[0] == SRC_MASTER && prescale[0] == 3'h0 && !wr_cfg[0] ##1 !wr_cfg[0]
    |-> prog_clock_out[0] != $past(prog_clock_out[0]))
    else $error("master clock source not followed");
  a_div_four_period: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(prog_clock_out[0]) && src_sel[0] == SRC_MASTER && prescale[0] == 3'h1
    && !wr_cfg[0] ##0 !wr_cfg[0] [*2]
    |-> prog_clock_out[0] ##1 !prog_clock_out[0])
    else $error("divide by four period wrong");
  a_enable_sets_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_irq_en && !wr_irq_dis |=> ((imr & $past(hwdata) & IRQ_VALID_BITS)
    == ($past(hwdata) & IRQ_VALID_BITS)))
    else $error("enable write did not set mask");
  a_disable_clears_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_irq_dis |=> (imr & $past(hwdata)) == 32'h0000_0000)
    else $error("disable write did not clear mask");
  a_status_lock: assert property (@(posedge hclk) disable iff (!hresetn)
    status_word[BIT_PLL_A_LOCKED] == $past(pll_a_locked, 2))
    else $error("lock status does not follow input");
  a_fail_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    clock_fail_event && !rd_status |=> clock_fail_event)
    else $error("clock fail event lost without read");
  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == $past(|(status_word & imr)))
    else $error("irq does not match masked status");
  a_ready_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_cfg[0] |=> !prog_clock_ready[0] && !prog_clock_out[0])
    else $error("ready not dropped on config write");
  c_ready_after_write: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_cfg[1] ##[1:200] prog_clock_ready[1]);
  c_irq_fires: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  c_fail_read: cover property (@(posedge hclk) disable iff (!hresetn)
    clock_fail_event && rd_status);
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// self-checking testbench for the programmable clock and clock status block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import prog_clock_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        write_protect_enable;
  logic        slow_src;
  logic        main_src;
  logic        pll_src;
  logic [8:0]  st;
  wire logic        hreadyout;
  wire logic [31:0] hrdata;
  wire logic        hresp;
  wire logic [2:0]  prog_clock_out;
  wire logic        irq;
  int          err_total;
  int          samples_checked;
  int          cycles;

  prog_clock_status prog_clock_status_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .write_protect_enable(write_protect_enable), .slow_clock_source(slow_src),
    .main_clock_source(main_src), .pll_a_clock_source(pll_src),
    .crystal_osc_stable(st[0]), .pll_a_locked(st[1]), .master_clock_ready(st[2]),
    .slow_osc_select_status(st[3]), .main_osc_switch_done(st[4]),
    .fast_rc_stable(st[5]), .clock_fail_status(st[6]), .fault_output_status(st[7]),
    .slow_crystal_freq_error(st[8]), .prog_clock_out(prog_clock_out), .irq(irq));

  // source clocks toggle on hclk falling edges: 10, 6 and 4 hclk per edge
  always #10 hclk = ~hclk;
  always #200 slow_src = ~slow_src;
  always #120 main_src = ~main_src;
  always #80 pll_src = ~pll_src;

  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check("hresp", 32'(HRESP_OKAY), 32'(hresp));
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(what, exp, x & m);
  endtask

  function automatic logic [31:0] st_exp(input logic [8:0] s, input logic fe);
    st_exp = {10'h000, s[8], s[7], s[6], fe, s[5], s[4], 8'h00, s[3], 3'h0, s[2], 1'h0,
              s[1], s[0]};
  endfunction

  task automatic t_status;
    logic [8:0] pats [4];
    pats = '{9'h000, 9'h1BF, 9'h0A5, 9'h11A};
    foreach (pats[i])
    begin
      @(posedge hclk);
      st <= pats[i];
      repeat (4) @(posedge hclk);
      rd_chk("status", ADDR_CLOCK_STATUS, 32'hFFFF_F8FF, st_exp(pats[i], 1'b0));
    end
  endtask

  task automatic t_fail;
    @(posedge hclk);
    st <= 9'h040;
    repeat (5) @(posedge hclk);
    st <= 9'h000;
    repeat (5) @(posedge hclk);
    rd_chk("fail event", ADDR_CLOCK_STATUS, 32'hFFFF_F8FF, st_exp(9'h000, 1'b1));
    rd_chk("fail clear", ADDR_CLOCK_STATUS, 32'hFFFF_F8FF, st_exp(9'h000, 1'b0));
  endtask

  task automatic t_mask;
    wr(ADDR_CLOCK_IRQ_DISABLE, 32'hFFFF_FFFF);
    rd_chk("mask none", ADDR_CLOCK_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
    wr(ADDR_CLOCK_IRQ_ENABLE, 32'hFFFF_FFFF);
    rd_chk("mask all", ADDR_CLOCK_IRQ_MASK, 32'hFFFF_FFFF, 32'h0027_070B);
    wr(ADDR_CLOCK_IRQ_DISABLE, 32'h0000_070B);
    rd_chk("mask dis", ADDR_CLOCK_IRQ_MASK, 32'hFFFF_FFFF, 32'h0027_0000);
    wr(ADDR_CLOCK_IRQ_ENABLE, 32'h0000_0000);
    wr(ADDR_CLOCK_IRQ_DISABLE, 32'h0000_0000);
    wr(ADDR_CLOCK_IRQ_MASK, 32'hFFFF_FFFF);
    rd_chk("mask keep", ADDR_CLOCK_IRQ_MASK, 32'hFFFF_FFFF, 32'h0027_0000);
    wr(ADDR_CLOCK_IRQ_DISABLE, 32'hFFFF_FFFF);
    wr(ADDR_CLOCK_IRQ_ENABLE, 32'h0000_0001);
    repeat (4) @(posedge hclk);
    check("irq idle", 32'h0, 32'(irq));
    st <= 9'h001;
    repeat (5) @(posedge hclk);
    check("irq on", 32'h1, 32'(irq));
    wr(ADDR_CLOCK_IRQ_DISABLE, 32'h0000_0001);
    repeat (3) @(posedge hclk);
    check("irq off", 32'h0, 32'(irq));
    st <= 9'h000;
  endtask

  task automatic wait_lvl(input int ch, input logic lvl, inout int n);
    while (prog_clock_out[ch] !== lvl && n < 4000)
    begin
      @(posedge hclk);
      n++;
    end
  endtask

  task automatic t_prog;
    int src_tab [8];
    int div_tab [8];
    int half [5];
    int ch;
    int n;
    src_tab = '{0, 1, 2, 4, 4, 4, 4, 1};
    div_tab = '{1, 2, 3, 0, 6, 5, 1, 4};
    half = '{10, 6, 4, 0, 1};
    foreach (src_tab[i])
    begin
      ch = i % 3;
      wr(ADDR_PROG_CLOCK_CONFIG0 + 32'(ch * 4), 32'(div_tab[i] * 16 + src_tab[i]));
      n = 0;
      wait_lvl(ch, 1'b1, n);
      wait_lvl(ch, 1'b0, n);
      wait_lvl(ch, 1'b1, n);
      n = 0;
      wait_lvl(ch, 1'b0, n);
      wait_lvl(ch, 1'b1, n);
      check("period", 32'(2 * half[src_tab[i]] * (1 << div_tab[i])), 32'(n));
    end
    wr(ADDR_PROG_CLOCK_CONFIG0, 32'h0000_0060);
    rd_chk("ready low", ADDR_CLOCK_STATUS, 32'h0000_0100, 32'h0000_0000);
    n = 0;
    wait_lvl(0, 1'b1, n);
    repeat (2) @(posedge hclk);
    rd_chk("ready high", ADDR_CLOCK_STATUS, 32'h0000_0700, 32'h0000_0700);
  endtask

  task automatic t_protect;
    wr(ADDR_PROG_CLOCK_CONFIG0 + 32'h4, 32'hFFFF_FF21);
    rd_chk("cfg", ADDR_PROG_CLOCK_CONFIG0 + 32'h4, 32'hFFFF_FFFF, 32'h0000_0021);
    @(posedge hclk);
    write_protect_enable <= 1'b1;
    wr(ADDR_PROG_CLOCK_CONFIG0, 32'h0000_0004);
    rd_chk("cfg wp", ADDR_PROG_CLOCK_CONFIG0, 32'hFFFF_FFFF, 32'h0000_0060);
    write_protect_enable <= 1'b0;
    rd_chk("unmapped", 32'h400E_0450, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask

  initial
  begin
    hclk = 1'b0;
    slow_src = 1'b0;
    main_src = 1'b0;
    pll_src = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    write_protect_enable = 1'b0;
    st = 9'h000;
    err_total = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_status();
    t_fail();
    t_mask();
    t_prog();
    t_protect();
    complete_run();
  end
endmodule
`default_nettype wire
